// ### cls_map.vh
// Operation
// (R1) With loss reaction 0 a lost link lets the current run go on.
// (R2) With loss reaction 1 a lost link aborts any run in progress.
// (R3) With loss reaction 2 a lost link starts a safe run; 3 is reserved.
// (R4) The loss reaction acts only on a link that came up and was lost.
// (R5) With power-up field 0 no safe run is made at power-up.
// (R6) Fields 1 to 3 start a safe run if no link comes in 15, 30, 60 s.
// (R7) Every safe run targets the signed safe-position parameter.
// (R8) A failed safe run is retried after the repetition time in seconds.
// (R9) A repetition time of zero disables retries.
// (R10) The power-up timer stops without a run if a link comes first.
// (R11) The retry timer clears on a successful safe run or a new link.
`ifndef CLS_MAP_VH
`define CLS_MAP_VH
`define CLS_REG_CFG       8'h76
`define CLS_REG_SAFE_POS  8'h78
`define CLS_REG_RETRY     8'h7A
`define CLS_CFG_RESET     16'h0001
`define CLS_POS_RESET     32'h00000000
`define CLS_RETRY_RESET   16'h0000
`define CLS_LOSS_LSB      0
`define CLS_PWR_LSB       2
`define CLS_LOSS_CONTINUE 2'h0
`define CLS_LOSS_ABORT    2'h1
`define CLS_LOSS_SAFE     2'h2
`define CLS_PWR_NONE      2'h0
`define CLS_PWR_15        2'h1
`define CLS_PWR_30        2'h2
`define CLS_PWR_60        2'h3
`define CLS_CLK_HZ        32'h07735940
`define CLS_T15_S         16'h000F
`define CLS_T30_S         16'h001E
`define CLS_T60_S         16'h003C
`endif

// ### cls_scanner_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Scanner that opens and drops the link
// ----------------------------------------
module cls_scanner_model (
   input  wire       clk,      // Device clock.
   input  wire       rstn,     // Reset, active low.
   input  wire       link_req, // Bench wants the link up.
   input  wire [3:0] delay,    // Cycles taken to connect.
   output reg        conn_up   // Connection held.
);
   reg [3:0] cnt;
   // A dropped request loses the link at once, as a cable pull would.
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt     <= 4'h0;
         conn_up <= 1'b0;
      end else if (!link_req) begin
         cnt     <= 4'h0;
         conn_up <= 1'b0;
      end else if (cnt == delay) begin
         conn_up <= 1'b1;
      end else begin
         cnt <= cnt + 4'h1;
      end
   end
endmodule

// ### cls_sec_tick.v
`timescale 1ns/1ps
`include "cls_map.vh"
module cls_sec_tick #(
   parameter SEC_CYCLES = `CLS_CLK_HZ
) (
   input  wire clk,        // Device clock.
   input  wire rst_n,      // Synchronised reset, active low.
   input  wire restart,    // Restarts the second from zero.
   output reg  tick        // One-cycle pulse once per second.
);
   reg [31:0] cnt;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt  <= 32'h00000000;
         tick <= 1'b0;
      end else if (restart) begin
         cnt  <= 32'h00000000;
         tick <= 1'b0;
      end else if (cnt == SEC_CYCLES - 1) begin
         cnt  <= 32'h00000000;
         tick <= 1'b1;
      end else begin
         cnt  <= cnt + 32'h00000001;
         tick <= 1'b0;
      end
   end
endmodule

// ### cls_supervisor.v
`timescale 1ns/1ps
`include "cls_map.vh"
module cls_supervisor #(
   parameter SEC_CYCLES = `CLS_CLK_HZ
) (
   input  wire        clk,         // Device clock, 125 MHz.
   input  wire        rstn,        // Power-up reset, active low.
   input  wire        reg_wr,      // Parameter write strobe.
   input  wire [7:0]  reg_addr,    // Parameter number.
   input  wire [31:0] reg_wdata,   // Parameter write data.
   output reg  [31:0] reg_rdata,   // Parameter read data.
   input  wire        conn_up,     // Cyclic connection established.
   input  wire        run_busy,    // Positioning run in progress.
   input  wire        run_done,    // Run reached its target, pulse.
   input  wire        run_fail,    // Run failed, pulse.
   output reg         abort_run,   // Abort current run, pulse.
   output reg         safe_start,  // Start safe-position run, pulse.
   output reg  [31:0] safe_target, // Target of the safe run.
   output reg         safe_active  // Safe run outstanding.
);
   // -----------------------------------------------------------------
   // Reset release
   // -----------------------------------------------------------------
   // The pin may rise at any time; two flops make every register leave
   // reset on the same clock edge instead of on a partly settled one.
   reg rs1;
   reg rst_n;
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rs1   <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rs1   <= 1'b1;
         rst_n <= rs1;
      end
   end

   // -----------------------------------------------------------------
   // Parameters
   // -----------------------------------------------------------------
   reg [15:0] cfg;
   reg [31:0] safe_pos;
   reg [15:0] retry_s;
   wire [1:0] loss_sel = cfg[`CLS_LOSS_LSB+1:`CLS_LOSS_LSB];
   wire [1:0] pwr_sel  = cfg[`CLS_PWR_LSB+1:`CLS_PWR_LSB];

   // One-hot parameter select, shared by the write and the read path so
   // that both agree on which numbers are mapped; others select nothing.
   function [2:0] param_sel;
      input [7:0] addr;
      begin
         case (addr)
            `CLS_REG_CFG:      param_sel = 3'h1;
            `CLS_REG_SAFE_POS: param_sel = 3'h2;
            `CLS_REG_RETRY:    param_sel = 3'h4;
            default:           param_sel = 3'h0;
         endcase
      end
   endfunction

   wire [2:0] wr_sel   = param_sel(reg_addr) & {3{reg_wr}};
   wire [2:0] rd_sel   = param_sel(reg_addr);

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg      <= `CLS_CFG_RESET;
         safe_pos <= `CLS_POS_RESET;
         retry_s  <= `CLS_RETRY_RESET;
      end else begin
         if (wr_sel[0]) begin
            cfg <= reg_wdata[15:0];
         end
         if (wr_sel[1]) begin
            safe_pos <= reg_wdata;
         end
         if (wr_sel[2]) begin
            retry_s <= reg_wdata[15:0];
         end
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 32'h00000000;
      end else begin
         case (rd_sel)
            3'h1:    reg_rdata <= {16'h0000, cfg};
            3'h2:    reg_rdata <= safe_pos;
            3'h4:    reg_rdata <= {16'h0000, retry_s};
            default: reg_rdata <= 32'h00000000;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Timers
   // -----------------------------------------------------------------
   function [15:0] pwr_delay;
      input [1:0] sel;
      begin
         case (sel)
            `CLS_PWR_15: pwr_delay = `CLS_T15_S;
            `CLS_PWR_30: pwr_delay = `CLS_T30_S;
            `CLS_PWR_60: pwr_delay = `CLS_T60_S;
            default:     pwr_delay = 16'h0000;
         endcase
      end
   endfunction

   localparam ST_BOOT  = 2'h0;
   localparam ST_LINK  = 2'h1;
   localparam ST_LOST  = 2'h2;
   localparam ST_IDLE  = 2'h3;

   reg  [1:0]  state;
   reg         conn_d;
   reg  [15:0] sec_cnt;
   reg         retry_wait;
   wire        tick;
   wire        conn_rise = conn_up & ~conn_d;
   wire        conn_fall = ~conn_up & conn_d;
   wire        restart = conn_rise | conn_fall | (run_fail & safe_active);

   // The second restarts on every link edge and on a failed safe run, so
   // each delay counts whole seconds from its own starting event. One
   // count serves both delays; the power-up wait is over before a retry.
   cls_sec_tick #(
      .SEC_CYCLES (SEC_CYCLES)
   ) u_tick (
      .clk     (clk),
      .rst_n   (rst_n),
      .restart (restart),
      .tick    (tick)
   );

   // -----------------------------------------------------------------
   // Supervision
   // -----------------------------------------------------------------
   // Retries run only while the link is down; a returning connection
   // hands control back to the scanner.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state       <= ST_BOOT;
         conn_d      <= 1'b0;
         sec_cnt     <= 16'h0000;
         retry_wait  <= 1'b0;
         abort_run   <= 1'b0;
         safe_start  <= 1'b0;
         safe_active <= 1'b0;
         safe_target <= 32'h00000000;
      end else begin
         conn_d     <= conn_up;
         abort_run  <= 1'b0;
         safe_start <= 1'b0;
         if (conn_rise) begin
            state       <= ST_LINK;           // R10
            retry_wait  <= 1'b0;              // R11
            safe_active <= 1'b0;
            sec_cnt     <= 16'h0000;
         end else begin
            case (state)
               ST_BOOT: begin
                  // A zero field parks the count, so a later write of a
                  // delay counts the second already under way as its first.
                  if (pwr_sel == `CLS_PWR_NONE) begin
                     sec_cnt <= 16'h0000;     // R5
                  end else if (tick) begin
                     if (sec_cnt + 16'h0001 >= pwr_delay(pwr_sel)) begin
                        safe_start  <= 1'b1;  // R6
                        safe_active <= 1'b1;
                        safe_target <= safe_pos; // R7
                        state       <= ST_IDLE;
                        sec_cnt     <= 16'h0000;
                     end else begin
                        sec_cnt <= sec_cnt + 16'h0001;
                     end
                  end
               end
               ST_LINK: begin
                  if (conn_fall) begin        // R4
                     state <= ST_LOST;
                     // Abort only when a run is moving, so an idle drive
                     // never sees a stray abort.
                     case (loss_sel)
                        `CLS_LOSS_CONTINUE:
                           abort_run <= 1'b0; // R1
                        `CLS_LOSS_ABORT:
                           abort_run <= run_busy; // R2
                        `CLS_LOSS_SAFE: begin
                           safe_start  <= 1'b1;   // R3
                           safe_active <= 1'b1;
                           safe_target <= safe_pos; // R7
                        end
                        // Reserved code 3 is taken as continue.
                        default: abort_run <= 1'b0; // R3
                     endcase
                  end
               end
               default: begin
                  if (safe_active && run_done) begin
                     safe_active <= 1'b0;
                     retry_wait  <= 1'b0;     // R11
                     sec_cnt     <= 16'h0000;
                  end else if (safe_active && run_fail) begin
                     retry_wait <= (retry_s != 16'h0000); // R9
                     sec_cnt    <= 16'h0000;
                  end else if (retry_wait && tick) begin
                     if (sec_cnt + 16'h0001 >= retry_s) begin
                        retry_wait  <= 1'b0;
                        safe_start  <= 1'b1;  // R8
                        safe_target <= safe_pos; // R7
                        sec_cnt     <= 16'h0000;
                     end else begin
                        sec_cnt <= sec_cnt + 16'h0001;
                     end
                  end
               end
            endcase
         end
      end
   end
endmodule

// ### cls_supervisor_asserts.sv
`timescale 1ns/1ps
// ----------------------------------------
// Checker on the supervisor ports
// ----------------------------------------
module cls_supervisor_asserts (
   input wire        clk,         // Device clock.
   input wire        rstn,        // Power-up reset, active low.
   input wire        conn_up,     // Connection level.
   input wire        run_busy,    // Run in progress.
   input wire        run_done,    // Run reached target.
   input wire        abort_run,   // Abort pulse.
   input wire        safe_start,  // Safe-run start pulse.
   input wire [31:0] safe_target, // Safe-run target.
   input wire        safe_active  // Safe run outstanding.
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   property p_abort_pulse; abort_run |=> !abort_run; endproperty
   // An abort needs a busy run and a link that was up and then fell.
   property p_abort_cause;
      abort_run |-> !conn_up && ($past(conn_up, 2) || $past(conn_up, 3))
         && ($past(run_busy) || $past(run_busy, 2));
   endproperty
   property p_start_pulse; safe_start |=> !safe_start; endproperty
   property p_start_active; safe_start |=> safe_active; endproperty
   property p_target_hold; !safe_start |-> $stable(safe_target); endproperty
   property p_no_start_up;
      conn_up && $past(conn_up) && $past(conn_up, 2) |-> !safe_start;
   endproperty
   property p_conn_clear; $rose(conn_up) |-> ##[1:3] !safe_active; endproperty
   property p_done_clear;
      run_done && !safe_start |-> ##[1:2] !safe_active;
   endproperty
   a_abort_pulse: assert property (p_abort_pulse)
      else $error("abort pulse longer than one cycle");
   a_abort_cause: assert property (p_abort_cause)
      else $error("abort without a lost link and a busy run");
   a_start_pulse: assert property (p_start_pulse)
      else $error("safe start longer than one cycle");
   a_start_active: assert property (p_start_active)
      else $error("safe run not marked active after start");
   a_target_hold: assert property (p_target_hold)
      else $error("safe target moved without a start");
   a_no_start_up: assert property (p_no_start_up)
      else $error("safe run started while the link is up");
   a_conn_clear: assert property (p_conn_clear)
      else $error("safe run still active after the link came up");
   a_done_clear: assert property (p_done_clear)
      else $error("safe run still active after it completed");
   c_abort: cover property (abort_run);
   c_start: cover property (safe_start ##1 safe_active);
   c_conn: cover property ($rose(conn_up) && safe_active);
endmodule
bind cls_supervisor cls_supervisor_asserts u_chk (.clk, .rstn, .conn_up,
   .run_busy, .run_done, .abort_run, .safe_start, .safe_target,
   .safe_active);

// ### test_connection_loss_safe_positioning.sv
`timescale 1ns/1ps
`include "cls_map.vh"
module test_connection_loss_safe_positioning;
   localparam SC = 10;
   logic        clk = 0, rstn = 0, reg_wr = 0, run_busy = 0, run_done = 0;
   logic        run_fail = 0, link_req = 0;
   logic [7:0]  reg_addr = 8'h00;
   logic [3:0]  delay = 4'h3;
   logic [31:0] reg_wdata = 32'h0, pos, reg_rdata, safe_target;
   wire         conn_up, abort_run, safe_start, safe_active;
   int          err_count = 0, n_tests = 0, cyc = 0, ns, na, t, t0;
   cls_supervisor #(.SEC_CYCLES(SC)) dut (.clk, .rstn, .reg_wr, .reg_addr,
      .reg_wdata, .reg_rdata, .conn_up, .run_busy, .run_done, .run_fail,
      .abort_run, .safe_start, .safe_target, .safe_active);
   cls_scanner_model scan (.clk, .rstn, .link_req, .delay, .conn_up);
   initial forever #4 clk = ~clk;
   task end_of_test;
      $display("mismatches %0d checks %0d", err_count, n_tests);
      if (err_count == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 10000) begin
         err_count++;
         end_of_test;
      end
   end
   task chk(input logic [31:0] g, e);
      n_tests++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      @(negedge clk) {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
      @(negedge clk) reg_wr = 0;
   endtask
   task rd(input [7:0] a, input [31:0] e);
      @(negedge clk) reg_addr = a;
      @(negedge clk) chk(reg_rdata, e);
   endtask
   // Each case restarts from power-up so the power-up timer is fresh.
   task rst(input [31:0] cfg, rt);
      {rstn, link_req, run_busy} = 0;
      repeat (10) @(negedge clk);
      rstn = 1;
      t0 = cyc;
      pos = $urandom;
      repeat (2) @(negedge clk);
      wr(`CLS_REG_CFG, cfg);
      wr(`CLS_REG_SAFE_POS, pos);
      wr(`CLS_REG_RETRY, rt);
   endtask
   task watch(input int n);
      {ns, na, t} = {32'd0, 32'd0, -32'd1};
      repeat (n) begin
         @(negedge clk);
         na += (abort_run === 1'b1);
         if (safe_start === 1'b1) begin
            ns++;
            if (t < 0) t = cyc;
            chk(safe_target, pos);
         end
      end
   endtask
   function int tmo(int p);
      return (p == 1 ? `CLS_T15_S : p == 2 ? `CLS_T30_S : `CLS_T60_S) * SC;
   endfunction
   initial begin
      void'($urandom(32'h2065));
      repeat (10) @(negedge clk);
      rstn = 1;
      repeat (2) @(negedge clk);
      rd(`CLS_REG_CFG, `CLS_CFG_RESET);
      rd(`CLS_REG_SAFE_POS, `CLS_POS_RESET);
      rd(`CLS_REG_RETRY, `CLS_RETRY_RESET);
      rd(8'h77, 32'h0);
      wr(`CLS_REG_RETRY, 32'h5);
      rd(`CLS_REG_RETRY, 32'h5);
      $display("register test done");
      for (int p = 0; p < 4; p++) begin
         rst({p[1:0], 2'b00}, p == 3 ? 0 : 2);
         watch(p == 0 ? 700 : tmo(p) + 10);
         chk(ns, p > 0);
         if (p > 0)
            chk((t - t0) >= tmo(p) - 2 && (t - t0) <= tmo(p) + 6, 1);
         @(negedge clk) run_fail = 1;
         t0 = cyc;
         @(negedge clk) run_fail = 0;
         watch(2 * SC + 10);
         chk(ns, p == 1 || p == 2);
         if (p == 1 || p == 2)
            chk(t - t0 >= 2 * SC && t - t0 <= 2 * SC + 4, 1);
         @(negedge clk) run_done = 1;
         @(negedge clk) run_done = 0;
         repeat (3) @(negedge clk);
         chk(safe_active, 0);
      end
      $display("power-up test done");
      for (int c = 0; c < 4; c++) begin
         rst({2'b01, c[1:0]}, 0);
         delay = $urandom_range(1, 15);
         link_req = 1;
         watch(200);
         chk(ns, 0);
         {run_busy, link_req} = 2'b10;
         watch(6);
         chk(na, c == 1);
         chk(ns, c == 2);
         link_req = 1;
         repeat (20) @(negedge clk);
         chk(safe_active, 0);
      end
      $display("loss test done");
      end_of_test;
   end
endmodule
